// *** common/wdt_pkg.sv ***
// constants and types for the indexed-port watchdog timer
// assumes a single 50 MHz system clock shared by host port logic and the timer
package wdt_pkg;

  // ****************************************
  // port addresses and keys
  // ****************************************
  localparam logic [15:0] INDEX_PORT = 16'h002E;
  localparam logic [15:0] DATA_PORT = 16'h002F;
  localparam logic [7:0] UNLOCK_KEY = 8'h87;
  localparam logic [7:0] LOCK_KEY = 8'hAA;

  // ****************************************
  // register indices and values
  // ****************************************
  localparam logic [7:0] REG_GROUP_SEL = 8'h07;
  localparam logic [7:0] WDT_GROUP = 8'h08;
  localparam logic [7:0] REG_ACTIVATE = 8'h30;
  localparam logic [7:0] ACTIVATE_ON = 8'h01;
  localparam logic [7:0] REG_TIME_BASE = 8'hF5;
  localparam logic [7:0] REG_COUNT = 8'hF6;
  localparam logic [7:0] REG_CTRL = 8'hF7;

  // ****************************************
  // field positions
  // ****************************************
  localparam int TB_MINUTE_BIT = 3;
  localparam int CTRL_MOUSE_BIT = 7;
  localparam int CTRL_KBD_BIT = 6;
  localparam int CTRL_FORCE_BIT = 5;
  localparam int CTRL_STATUS_BIT = 4;

  // ****************************************
  // values after reset
  // ****************************************
  localparam logic [7:0] GROUP_RST = 8'h00;
  localparam logic [7:0] ACTIVATE_RST = 8'h00;
  localparam logic [7:0] TIME_BASE_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] INDEX_RST = 8'h00;
  localparam logic [7:0] IDLE_READ = 8'h00;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_FREQ_HZ = 50000000;
  localparam int SECOND_PERIOD_MS = 1000;
  localparam int SECOND_CYCLES = CLK_FREQ_HZ / 1000 * SECOND_PERIOD_MS;
  localparam int MINUTE_SECONDS = 60;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    LOCKED = 2'b00,
    KEY_HALF = 2'b01,
    UNLOCKED = 2'b10
  } lock_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } io_req_t;

  typedef struct packed {
    logic mouse;
    logic kbd;
    logic dest_irq;
  } pin_in_t;

endpackage

// *** logic/sync2.sv ***
// two-flop synchroniser for a group of asynchronous level inputs
// assumes inputs change slowly compared with clk
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      q <= '0;
    end else if (clk_en) begin
      meta <= d;
      q <= meta;
    end
  end

endmodule
`default_nettype wire

// *** logic/time_base_tick.sv ***
// seconds or minutes tick for the watchdog count
// assumes restart comes from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module time_base_tick
  import wdt_pkg::*;
#(
  parameter int SECOND_CYCLES = wdt_pkg::SECOND_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic restart,
  input wire logic minute_mode,
  output logic tick
);

  logic [31:0] cycle_cnt;
  logic [5:0] sec_cnt;
  logic sec_end;
  logic min_end;

  assign sec_end = (cycle_cnt == 32'(SECOND_CYCLES - 1));
  assign min_end = (sec_cnt == 6'(MINUTE_SECONDS - 1));

  // prescaler restarts with the count so a period is whole
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cycle_cnt <= '0;
    end else if (clk_en) begin
      if (restart || sec_end) begin
        cycle_cnt <= '0;
      end else begin
        cycle_cnt <= cycle_cnt + 32'h00000001;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sec_cnt <= '0;
    end else if (clk_en) begin
      if (restart) begin
        sec_cnt <= '0;
      end else if (sec_end) begin
        sec_cnt <= min_end ? 6'h00 : sec_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick <= 1'b0;
    end else if (clk_en) begin
      tick <= !restart && sec_end && (!minute_mode || min_end);
    end
  end

endmodule
`default_nettype wire

// *** logic/indexed_port_watchdog_timer.sv ***
// top of the watchdog timer reached through an index and a data port
// assumes host port cycles are one-cycle strobes on clk; activity and
// destination pins are asynchronous
`timescale 1ns/100ps
`default_nettype none
module indexed_port_watchdog_timer #(
  parameter int SECOND_CYCLES = wdt_pkg::SECOND_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire wdt_pkg::io_req_t io_req,
  input wire logic kbd_activity,
  input wire logic mouse_activity,
  input wire logic timeout_destination_selector,
  output logic [7:0] io_rdata,
  output logic io_rdata_valid,
  output logic wdt_irq_n,
  output logic wdt_reset
);
  import wdt_pkg::*;

  // ****************************************
  // pin synchronisation
  // ****************************************
  pin_in_t pins_raw;
  pin_in_t pins;
  logic kbd_prev;
  logic mouse_prev;
  logic kbd_edge;
  logic mouse_edge;

  assign pins_raw = '{mouse: mouse_activity, kbd: kbd_activity,
                      dest_irq: timeout_destination_selector};

  sync2 #(
    .WIDTH($bits(pin_in_t))
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .d(pins_raw),
    .q(pins)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      kbd_prev <= 1'b0;
      mouse_prev <= 1'b0;
    end else if (clk_en) begin
      kbd_prev <= pins.kbd;
      mouse_prev <= pins.mouse;
    end
  end

  assign kbd_edge = pins.kbd && !kbd_prev;
  assign mouse_edge = pins.mouse && !mouse_prev;

  // ****************************************
  // port decode
  // ****************************************
  lock_state_t lock_state;
  logic [7:0] index;
  logic [7:0] group;
  logic [7:0] activate;
  logic [7:0] time_base;
  logic [7:0] count_reg;
  logic ctrl_kbd;
  logic ctrl_mouse;
  logic idx_wr;
  logic idx_rd;
  logic data_wr;
  logic data_rd;
  logic cfg_open;
  logic cfg_wr;
  logic wd_wr;
  logic wr_group;
  logic wr_act;
  logic wr_tb;
  logic wr_cnt;
  logic wr_ctrl;
  logic force_wr;
  logic wdt_active;

  always_comb begin
    idx_wr = io_req.wr && (io_req.addr == INDEX_PORT);
    idx_rd = io_req.rd && (io_req.addr == INDEX_PORT);
    data_wr = io_req.wr && (io_req.addr == DATA_PORT);
    data_rd = io_req.rd && (io_req.addr == DATA_PORT);
    cfg_open = (lock_state == UNLOCKED);
    cfg_wr = data_wr && cfg_open;
    wd_wr = cfg_wr && (group == WDT_GROUP);
    wr_group = cfg_wr && (index == REG_GROUP_SEL);
    wr_act = wd_wr && (index == REG_ACTIVATE);
    wr_tb = wd_wr && (index == REG_TIME_BASE);
    wr_cnt = wd_wr && (index == REG_COUNT);
    wr_ctrl = wd_wr && (index == REG_CTRL);
    force_wr = wr_ctrl && io_req.wdata[CTRL_FORCE_BIT];
  end

  assign wdt_active = (activate == ACTIVATE_ON);

  // ****************************************
  // unlock sequence and index register
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_state <= LOCKED;
    end else if (clk_en && idx_wr) begin
      case (lock_state)
        LOCKED: begin
          lock_state <= (io_req.wdata == UNLOCK_KEY) ? KEY_HALF : LOCKED;
        end
        KEY_HALF: begin
          lock_state <= (io_req.wdata == UNLOCK_KEY) ? UNLOCKED : LOCKED;
        end
        UNLOCKED: begin
          if (io_req.wdata == LOCK_KEY) begin
            lock_state <= LOCKED;
          end
        end
        default: begin
          lock_state <= LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      index <= INDEX_RST;
    end else if (clk_en && idx_wr && cfg_open && io_req.wdata != LOCK_KEY) begin
      index <= io_req.wdata;
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      group <= GROUP_RST;
    end else if (clk_en && wr_group) begin
      group <= io_req.wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      activate <= ACTIVATE_RST;
    end else if (clk_en && wr_act) begin
      activate <= io_req.wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      time_base <= TIME_BASE_RST;
    end else if (clk_en && wr_tb) begin
      time_base <= io_req.wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= COUNT_RST;
    end else if (clk_en && wr_cnt) begin
      count_reg <= io_req.wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_kbd <= 1'b0;
      ctrl_mouse <= 1'b0;
    end else if (clk_en && wr_ctrl) begin
      ctrl_kbd <= io_req.wdata[CTRL_KBD_BIT];
      ctrl_mouse <= io_req.wdata[CTRL_MOUSE_BIT];
    end
  end

  // ****************************************
  // countdown
  // ****************************************
  logic [7:0] run_count;
  logic expired;
  logic tick;
  logic act_restart;
  logic restart;

  assign act_restart = (kbd_edge && ctrl_kbd) || (mouse_edge && ctrl_mouse);
  assign restart = wr_cnt || act_restart;

  time_base_tick #(
    .SECOND_CYCLES(SECOND_CYCLES)
  ) u_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .restart(restart),
    .minute_mode(time_base[TB_MINUTE_BIT]),
    .tick(tick)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_count <= COUNT_RST;
      expired <= 1'b0;
    end else if (clk_en) begin
      if (wr_cnt) begin
        run_count <= io_req.wdata;
        expired <= 1'b0;
      end else if (act_restart) begin
        run_count <= count_reg;
        expired <= 1'b0;
      end else if (tick && wdt_active && run_count != 8'h00) begin
        run_count <= run_count - 8'h01;
        if (run_count == 8'h01) begin
          expired <= 1'b1;
        end
      end
      // forced timeout wins over any clear in the same cycle
      if (force_wr) begin
        expired <= 1'b1;
      end
    end
  end

  // ****************************************
  // timeout outputs
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdt_irq_n <= 1'b1;
      wdt_reset <= 1'b0;
    end else if (clk_en) begin
      wdt_irq_n <= !(expired && wdt_active && pins.dest_irq);
      wdt_reset <= expired && wdt_active && !pins.dest_irq;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      io_rdata <= IDLE_READ;
      io_rdata_valid <= 1'b0;
    end else if (clk_en) begin
      io_rdata_valid <= idx_rd || data_rd;
      if (idx_rd && cfg_open) begin
        io_rdata <= index;
      end else if (!data_rd || !cfg_open) begin
        io_rdata <= IDLE_READ;
      end else if (index == REG_GROUP_SEL) begin
        io_rdata <= group;
      end else if (group != WDT_GROUP) begin
        io_rdata <= IDLE_READ;
      end else if (index == REG_ACTIVATE) begin
        io_rdata <= activate;
      end else if (index == REG_TIME_BASE) begin
        io_rdata <= time_base;
      end else if (index == REG_COUNT) begin
        io_rdata <= count_reg;
      end else if (index == REG_CTRL) begin
        io_rdata <= {ctrl_mouse, ctrl_kbd, 1'b0, expired, 4'h0};
      end else begin
        io_rdata <= IDLE_READ;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_off_quiet;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && !wdt_active) |=> (wdt_irq_n && !wdt_reset);
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("timeout output while off");

  property p_count_step;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && tick && wdt_active && !restart && run_count > 8'h01)
      |=> (run_count == $past(run_count) - 8'h01) && (expired == $past(expired || force_wr));
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not drop by one");

  property p_expiry;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && tick && wdt_active && !restart && run_count == 8'h01) |=> expired;
  endproperty
  a_expiry: assert property (p_expiry) else $error("no expiry at zero");

  property p_irq_out;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && expired && wdt_active && pins.dest_irq) |=> (!wdt_irq_n && !wdt_reset);
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("interrupt not driven low");

  property p_irq_hold;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && expired && !wdt_irq_n && !restart && wdt_active && pins.dest_irq && !wr_act)
      |=> !wdt_irq_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt released early");

  property p_unlock;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && lock_state == KEY_HALF && idx_wr && io_req.wdata == UNLOCK_KEY)
      |=> (lock_state == UNLOCKED);
  endproperty
  a_unlock: assert property (p_unlock) else $error("second key did not unlock");

  property p_relock;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && cfg_open && idx_wr && io_req.wdata == LOCK_KEY) |=> (lock_state == LOCKED);
  endproperty
  a_relock: assert property (p_relock) else $error("lock key ignored");

  property p_locked_ignore;
    @(posedge clk) disable iff (sys_rst)
    (lock_state != UNLOCKED && data_wr)
      |=> ($stable(count_reg) && $stable(activate) && $stable(group) && $stable(time_base));
  endproperty
  a_locked_ignore: assert property (p_locked_ignore) else $error("write while locked");

  property p_restart;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && wr_cnt && !force_wr) |=> (run_count == $past(io_req.wdata) && !expired);
  endproperty
  a_restart: assert property (p_restart) else $error("count write did not restart");

  property p_force;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && force_wr && wdt_active && !wr_act) |=> expired ##1 (!wdt_irq_n || wdt_reset);
  endproperty
  a_force: assert property (p_force) else $error("forced timeout missing");

  property p_status;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && data_rd && cfg_open && group == WDT_GROUP && index == REG_CTRL)
      |=> (io_rdata[CTRL_STATUS_BIT] == $past(expired) && !io_rdata[CTRL_FORCE_BIT]);
  endproperty
  a_status: assert property (p_status) else $error("status bit wrong");

endmodule
`default_nettype wire

// *** sim/io_host_model.sv ***
// host model issuing index and data port cycles to the watchdog
// assumes strobes are sampled on the rising edge of clk
`timescale 1ns/100ps
`default_nettype none
module io_host_model (
  input wire logic clk,
  input wire logic [7:0] io_rdata,
  input wire logic io_rdata_valid,
  output var wdt_pkg::io_req_t io_req
);
  import wdt_pkg::*;
  // ****************************************
  // port cycles
  // ****************************************
  initial begin
    io_req = '0;
  end
  // released bus shows the inverse of the last value
  task automatic drop();
    io_req.wr = 1'b0;
    io_req.rd = 1'b0;
    io_req.addr = ~io_req.addr;
    io_req.wdata = ~io_req.wdata;
  endtask
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_req.addr = a;
    io_req.wdata = d;
    io_req.wr = 1'b1;
    @(negedge clk);
    drop();
  endtask
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    io_req.addr = a;
    io_req.rd = 1'b1;
    @(negedge clk);
    drop();
    d = io_rdata;
    v = io_rdata_valid;
  endtask
  task automatic unlock();
    io_wr(INDEX_PORT, UNLOCK_KEY);
    io_wr(INDEX_PORT, UNLOCK_KEY);
  endtask
  task automatic reg_wr(input logic [7:0] i, input logic [7:0] d);
    io_wr(INDEX_PORT, i);
    io_wr(DATA_PORT, d);
  endtask
  task automatic reg_rd(input logic [7:0] i, output logic [7:0] d);
    logic v;
    io_wr(INDEX_PORT, i);
    io_rd(DATA_PORT, d, v);
  endtask
  task automatic lock();
    io_wr(INDEX_PORT, LOCK_KEY);
  endtask
endmodule
`default_nettype wire

// *** sim/indexed_port_watchdog_timer_test.sv ***
// self-checking bench for the indexed-port watchdog timer
// assumes io_host_model drives the port side; second length shortened
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("unexpected %s: expected %0h seen %0h", nm, e, g); \
    end \
  end
module indexed_port_watchdog_timer_test;
  import wdt_pkg::*;
  localparam int SC = 10;
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] tb;
    int cyc;
  } row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic kbd_activity = 1'b0;
  logic mouse_activity = 1'b0;
  logic timeout_destination_selector = 1'b1;
  io_req_t io_req;
  logic [7:0] io_rdata;
  logic io_rdata_valid;
  logic wdt_irq_n;
  logic wdt_reset;
  int fail_count = 0;
  int check_count = 0;
  logic [7:0] rd;
  logic v;
  int n;
  row_t rows [4];
  // ****************************************
  // harness
  // ****************************************
  always #10 clk = ~clk;
  indexed_port_watchdog_timer #(.SECOND_CYCLES(SC)) dut_u (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .io_req(io_req),
    .kbd_activity(kbd_activity),
    .mouse_activity(mouse_activity),
    .timeout_destination_selector(timeout_destination_selector),
    .io_rdata(io_rdata),
    .io_rdata_valid(io_rdata_valid),
    .wdt_irq_n(wdt_irq_n),
    .wdt_reset(wdt_reset)
  );
  io_host_model host_u (
    .clk(clk),
    .io_rdata(io_rdata),
    .io_rdata_valid(io_rdata_valid),
    .io_req(io_req)
  );
  function automatic logic fired();
    return (wdt_irq_n === 1'b0) || (wdt_reset === 1'b1);
  endfunction
  task automatic wait_cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wait_out(input int lim, output int k);
    k = 0;
    while (!fired() && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask
  task automatic pulse(input logic m);
    if (m) begin
      mouse_activity = 1'b1;
    end else begin
      kbd_activity = 1'b1;
    end
    wait_cyc(4);
    mouse_activity = 1'b0;
    kbd_activity = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #(20 * 20000);
    fail_count++;
    tally_and_finish();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    rows[0] = '{8'h01, 8'h00, 1 * SC};
    rows[1] = '{8'h03, 8'h00, 3 * SC};
    rows[2] = '{8'hFF, 8'h00, 255 * SC};
    rows[3] = '{8'h01, 8'h08, 60 * SC};
    wait_cyc(12);
    sys_rst = 1'b0;
    `CHK("irq_n", 1'b1, wdt_irq_n)
    `CHK("reset out", 1'b0, wdt_reset)
    host_u.io_rd(DATA_PORT, rd, v);
    `CHK("locked read", 8'h00, rd)
    host_u.io_rd(16'h0080, rd, v);
    `CHK("foreign valid", 1'b0, v)
    host_u.unlock();
    host_u.reg_wr(REG_COUNT, 8'h05);
    host_u.reg_rd(REG_COUNT, rd);
    `CHK("count no group", 8'h00, rd)
    host_u.reg_wr(REG_GROUP_SEL, WDT_GROUP);
    host_u.reg_wr(REG_COUNT, 8'h01);
    host_u.reg_rd(REG_COUNT, rd);
    `CHK("count", 8'h01, rd)
    host_u.io_rd(INDEX_PORT, rd, v);
    `CHK("index read", REG_COUNT, rd)
    `CHK("data valid", 1'b1, v)
    wait_cyc(30);
    `CHK("inactive", 1'b0, fired())
    host_u.reg_rd(REG_CTRL, rd);
    `CHK("ctrl reset", 8'h00, rd)
    host_u.reg_rd(REG_TIME_BASE, rd);
    `CHK("base reset", 8'h00, rd)
    host_u.lock();
    host_u.io_rd(DATA_PORT, rd, v);
    `CHK("relocked", 8'h00, rd)
    host_u.io_wr(INDEX_PORT, UNLOCK_KEY);
    host_u.io_wr(INDEX_PORT, 8'h00);
    host_u.io_wr(INDEX_PORT, UNLOCK_KEY);
    host_u.io_rd(DATA_PORT, rd, v);
    `CHK("broken key", 8'h00, rd)
    host_u.io_wr(DATA_PORT, 8'h09);
    host_u.io_wr(INDEX_PORT, UNLOCK_KEY);
    host_u.reg_rd(REG_COUNT, rd);
    `CHK("locked write", 8'h01, rd)
    host_u.reg_wr(REG_ACTIVATE, ACTIVATE_ON);
    foreach (rows[i]) begin
      host_u.reg_wr(REG_TIME_BASE, rows[i].tb);
      host_u.reg_wr(REG_COUNT, rows[i].cnt);
      wait_cyc(2);
      `CHK("cleared", 1'b0, fired())
      wait_out(rows[i].cyc + 20, n);
      `CHK("period", 1'b1, n >= rows[i].cyc - 2 && n <= rows[i].cyc + 14)
    end
    host_u.reg_rd(REG_CTRL, rd);
    `CHK("status", 8'h10, rd)
    wait_cyc(50);
    `CHK("held low", 1'b0, wdt_irq_n)
    host_u.reg_wr(REG_ACTIVATE, 8'h00);
    wait_cyc(2);
    `CHK("off", 1'b0, fired())
    host_u.reg_wr(REG_ACTIVATE, ACTIVATE_ON);
    host_u.reg_wr(REG_TIME_BASE, 8'h00);
    host_u.reg_wr(REG_COUNT, 8'h00);
    wait_cyc(40);
    `CHK("zero stops", 1'b0, fired())
    host_u.reg_wr(REG_COUNT, 8'h03);
    repeat (4) begin
      wait_cyc(15);
      host_u.reg_wr(REG_COUNT, 8'h03);
    end
    `CHK("rewrite", 1'b0, fired())
    clk_en = 1'b0;
    wait_cyc(60);
    `CHK("frozen", 1'b0, fired())
    clk_en = 1'b1;
    host_u.reg_wr(REG_CTRL, 8'h40);
    repeat (3) begin
      wait_cyc(18);
      pulse(1'b0);
    end
    `CHK("kbd restart", 1'b0, fired())
    wait_out(60, n);
    `CHK("expiry", 1'b1, fired())
    host_u.reg_wr(REG_CTRL, 8'h80);
    pulse(1'b0);
    wait_cyc(4);
    `CHK("kbd off", 1'b1, fired())
    pulse(1'b1);
    wait_cyc(4);
    `CHK("mouse restart", 1'b0, fired())
    host_u.reg_wr(REG_CTRL, 8'h20);
    wait_cyc(3);
    `CHK("force", 1'b1, fired())
    host_u.reg_rd(REG_CTRL, rd);
    `CHK("force clear", 8'h10, rd)
    timeout_destination_selector = 1'b0;
    wait_cyc(5);
    `CHK("reset dest", 1'b1, wdt_reset)
    `CHK("irq idle", 1'b1, wdt_irq_n)
    host_u.lock();
    host_u.reg_wr(REG_COUNT, 8'h05);
    wait_cyc(3);
    `CHK("locked count", 1'b1, fired())
    sys_rst = 1'b1;
    wait_cyc(2);
    `CHK("rst out", 1'b0, wdt_reset)
    sys_rst = 1'b0;
    wait_cyc(2);
    host_u.unlock();
    host_u.reg_wr(REG_GROUP_SEL, WDT_GROUP);
    host_u.reg_rd(REG_ACTIVATE, rd);
    `CHK("activate rst", 8'h00, rd)
    tally_and_finish();
  end
endmodule
`default_nettype wire
